// ==== verilog/gep_port.sv ====
// Purpose: General purpose and multi-function pin port
// Assumes: Pins and the 32 kHz reference are asynchronous; two-flop synchronised
// Notes: Control bits are plain ports; edge flags are sticky, set wins over clear
//
// Overview of operation
// - Per-pin direction for general purpose pins
// - Separate rising and falling edge interrupts
// - Optional per-pin debounce on general purpose pins, 16 to 24 ms
// - Multi-function pin: input, output or test
// - Thirty more pins usable as multi-function ports
`timescale 1ns/1ps
`include "gep_defs.svh"
module gep_port #(
    parameter int GP_N = `GEP_GP_PINS,
    parameter int MF_N = `GEP_MF_DEDICATED + `GEP_MF_EXTRA,
    parameter int DEB_TICKS = `GEP_DEB_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Reference clock, sampled as a level
    input wire logic i_ref_32k,
    // General purpose pins
    input wire logic [GP_N-1:0] i_gp_pin,
    output logic [GP_N-1:0] o_gp_pin,
    output logic [GP_N-1:0] o_gp_pin_oe,
    // General purpose control
    input wire logic [GP_N-1:0] i_gp_dir_out,
    input wire logic [GP_N-1:0] i_gp_out_val,
    input wire logic [GP_N-1:0] i_gp_deb_en,
    // Multi-function pins
    input wire logic [MF_N-1:0] i_mf_pin,
    output logic [MF_N-1:0] o_mf_pin,
    output logic [MF_N-1:0] o_mf_pin_oe,
    // Multi-function control and internal test signals
    input wire logic [MF_N-1:0] i_mf_port_en,
    input wire logic [2*MF_N-1:0] i_mf_mode,
    input wire logic [MF_N-1:0] i_mf_out_val,
    input wire logic [MF_N-1:0] i_mf_alt_val,
    // Input levels seen by software
    output logic [GP_N-1:0] o_gp_in,
    output logic [MF_N-1:0] o_mf_in,
    // Sticky edge flags and write-one-to-clear
    output logic [GP_N-1:0] o_gp_rise,
    output logic [GP_N-1:0] o_gp_fall,
    output logic [MF_N-1:0] o_mf_rise,
    output logic [MF_N-1:0] o_mf_fall,
    input wire logic [GP_N-1:0] i_gp_rise_clr,
    input wire logic [GP_N-1:0] i_gp_fall_clr,
    input wire logic [MF_N-1:0] i_mf_rise_clr,
    input wire logic [MF_N-1:0] i_mf_fall_clr
);
    import gep_pkg::*;

    if (GP_N < 1 || GP_N > 32 || MF_N < 1 || MF_N > 64) begin : g_bad_count
        $error("gep_port: pin count out of range");
    end

    function automatic gep_mf_mode_e mf_mode(input logic [2*MF_N-1:0] m, input int i);
        return gep_mf_mode_e'(m[2*i +: 2]);
    endfunction : mf_mode

    // Synchronisers; first stage is read only by the second
    logic [GP_N-1:0] gp_s1;
    logic [GP_N-1:0] gp_s2;
    logic [MF_N-1:0] mf_s1;
    logic [MF_N-1:0] mf_s2;
    logic ref_s1;
    logic ref_s2;
    logic ref_d;
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            gp_s1 <= '0;
            gp_s2 <= '0;
            mf_s1 <= '0;
            mf_s2 <= '0;
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_d <= 1'b0;
        end else begin
            gp_s1 <= i_gp_pin;
            gp_s2 <= gp_s1;
            mf_s1 <= i_mf_pin;
            mf_s2 <= mf_s1;
            ref_s1 <= i_ref_32k;
            ref_s2 <= ref_s1;
            ref_d <= ref_s2;
        end
    end

    // One pulse per reference period
    logic ref_tick;
    assign ref_tick = ref_s2 & ~ref_d;

    // Debounce per general purpose pin
    logic [GP_N-1:0] gp_deb;
    logic [GP_N-1:0] gp_eff;
    genvar g;
    generate
        for (g = 0; g < GP_N; g++) begin : g_deb
            gep_debounce #(
                .TICKS(DEB_TICKS)
            ) u_deb (
                .i_clk(i_clk),
                .i_rstn(i_rstn),
                .i_tick(ref_tick),
                .i_raw(gp_s2[g]),
                .o_level(gp_deb[g])
            );
            assign gp_eff[g] = i_gp_deb_en[g] ? gp_deb[g] : gp_s2[g];
        end
    endgenerate

    // Edge detection state
    logic [GP_N-1:0] gp_prev;
    logic [MF_N-1:0] mf_prev;
    logic [GP_N-1:0] gp_rise;
    logic [GP_N-1:0] gp_fall;
    logic [MF_N-1:0] mf_rise;
    logic [MF_N-1:0] mf_fall;
    logic [GP_N-1:0] next_gp_rise;
    logic [GP_N-1:0] next_gp_fall;
    logic [MF_N-1:0] next_mf_rise;
    logic [MF_N-1:0] next_mf_fall;
    logic [MF_N-1:0] mf_watch;

    // Edges only count on pins released to port use and not in test mode
    always_comb begin
        for (int i = 0; i < MF_N; i++) begin
            mf_watch[i] = i_mf_port_en[i] && (mf_mode(i_mf_mode, i) != GEP_MF_ALT);
        end
    end

    // Set beats clear when both land in one cycle
    always_comb begin
        next_gp_rise = (gp_rise & ~i_gp_rise_clr) | (gp_eff & ~gp_prev);
        next_gp_fall = (gp_fall & ~i_gp_fall_clr) | (~gp_eff & gp_prev);
        next_mf_rise = (mf_rise & ~i_mf_rise_clr) | (mf_watch & mf_s2 & ~mf_prev);
        next_mf_fall = (mf_fall & ~i_mf_fall_clr) | (mf_watch & ~mf_s2 & mf_prev);
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            gp_prev <= '0;
            mf_prev <= '0;
            gp_rise <= '0;
            gp_fall <= '0;
            mf_rise <= '0;
            mf_fall <= '0;
        end else begin
            gp_prev <= gp_eff;
            mf_prev <= mf_s2;
            gp_rise <= next_gp_rise;
            gp_fall <= next_gp_fall;
            mf_rise <= next_mf_rise;
            mf_fall <= next_mf_fall;
        end
    end

    // Pin drive
    logic [GP_N-1:0] gp_o;
    logic [GP_N-1:0] gp_oe;
    logic [MF_N-1:0] mf_o;
    logic [MF_N-1:0] mf_oe;
    logic [GP_N-1:0] next_gp_o;
    logic [GP_N-1:0] next_gp_oe;
    logic [MF_N-1:0] next_mf_o;
    logic [MF_N-1:0] next_mf_oe;

    always_comb begin
        next_gp_o = i_gp_out_val;
        next_gp_oe = i_gp_dir_out;
        for (int i = 0; i < MF_N; i++) begin
            next_mf_o[i] = 1'b0;
            next_mf_oe[i] = 1'b0;
            // Pins not released stay with their normal owner, so we leave them undriven
            if (i_mf_port_en[i]) begin
                case (mf_mode(i_mf_mode, i))
                    GEP_MF_INPUT: begin
                        next_mf_oe[i] = 1'b0;
                    end
                    GEP_MF_OUTPUT: begin
                        next_mf_o[i] = i_mf_out_val[i];
                        next_mf_oe[i] = 1'b1;
                    end
                    GEP_MF_ALT: begin
                        next_mf_o[i] = i_mf_alt_val[i];
                        next_mf_oe[i] = 1'b1;
                    end
                    default: begin
                        next_mf_oe[i] = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            gp_o <= '0;
            gp_oe <= '0;
            mf_o <= '0;
            mf_oe <= '0;
        end else begin
            gp_o <= next_gp_o;
            gp_oe <= next_gp_oe;
            mf_o <= next_mf_o;
            mf_oe <= next_mf_oe;
        end
    end

    assign o_gp_pin = gp_o;
    assign o_gp_pin_oe = gp_oe;
    assign o_mf_pin = mf_o;
    assign o_mf_pin_oe = mf_oe;
    assign o_gp_in = gp_prev;
    assign o_mf_in = mf_prev;
    assign o_gp_rise = gp_rise;
    assign o_gp_fall = gp_fall;
    assign o_mf_rise = mf_rise;
    assign o_mf_fall = mf_fall;
endmodule : gep_port

// ==== verilog/gep_defs.svh ====
// Purpose: Constants for the pin port with edge detect and debounce
// Assumes: 100 MHz system clock, 32.768 kHz reference sampled as a level
// Notes: Debounce window is counted in reference clock periods
`ifndef GEP_DEFS_SVH
`define GEP_DEFS_SVH
`define GEP_GP_PINS 7
`define GEP_MF_DEDICATED 2
`define GEP_MF_EXTRA 30
`define GEP_DEB_MIN_MS 16
`define GEP_DEB_MAX_MS 24
`define GEP_REF_HZ 32768
// Stable time in reference ticks: 16 ms rounded up
`define GEP_DEB_TICKS ((`GEP_DEB_MIN_MS * `GEP_REF_HZ + 999) / 1000)
`define GEP_DEB_CW 10
`endif

// ==== verilog/gep_pkg.sv ====
// Purpose: Types for the pin port
// Assumes: Nothing beyond the defs header
// Notes: Mode code of a multi-function pin
package gep_pkg;
    typedef enum logic [1:0] {
        GEP_MF_INPUT = 2'b00,
        GEP_MF_OUTPUT = 2'b01,
        GEP_MF_ALT = 2'b10,
        GEP_MF_RSVD = 2'b11
    } gep_mf_mode_e;
endpackage : gep_pkg

// ==== verilog/gep_debounce.sv ====
// Purpose: One pin debounce filter
// Assumes: i_tick is a one-cycle pulse per reference period
// Notes: Level accepted only after the stable count of ticks
`timescale 1ns/1ps
`include "gep_defs.svh"
module gep_debounce #(
    parameter int TICKS = `GEP_DEB_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Sample in and filtered level out
    input wire logic i_tick,
    input wire logic i_raw,
    output logic o_level
);
    import gep_pkg::*;
    logic [`GEP_DEB_CW-1:0] cnt;
    logic [`GEP_DEB_CW-1:0] next_cnt;
    logic level;
    logic next_level;

    // The counter width bounds the window; refuse what it cannot count
    if (TICKS < 1 || TICKS >= (1 << `GEP_DEB_CW)) begin : g_bad_ticks
        $error("gep_debounce: TICKS out of range");
    end

    always_comb begin
        next_cnt = cnt;
        next_level = level;
        if (i_raw == level) begin
            next_cnt = '0;
        end else if (i_tick) begin
            if (cnt == `GEP_DEB_CW'(TICKS - 1)) begin
                next_level = i_raw;
                next_cnt = '0;
            end else begin
                next_cnt = cnt + `GEP_DEB_CW'(1);
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt <= '0;
            level <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end

    assign o_level = level;
endmodule : gep_debounce

// ==== testbench/gep_port_assertions.sv ====
// Purpose: Port checks for the pin port
// Assumes: Pin 0 edge checks apply only while its debounce is off
// Notes: A gp rise flag or an mf fall flag may only drop under a clear
`timescale 1ns/1ps
module gep_port_assertions #(parameter int GP_N = 7, parameter int MF_N = 32) (
    // Clock, reset and controls
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [GP_N-1:0] i_gp_pin,
    input wire logic [GP_N-1:0] i_gp_deb_en,
    input wire logic [GP_N-1:0] i_gp_dir_out,
    input wire logic [GP_N-1:0] i_gp_rise_clr,
    input wire logic [MF_N-1:0] i_mf_port_en,
    input wire logic [2*MF_N-1:0] i_mf_mode,
    input wire logic [MF_N-1:0] i_mf_out_val,
    input wire logic [MF_N-1:0] i_mf_fall_clr,
    // Watched outputs
    input wire logic [GP_N-1:0] o_gp_pin_oe,
    input wire logic [GP_N-1:0] o_gp_rise,
    input wire logic [GP_N-1:0] o_gp_fall,
    input wire logic [MF_N-1:0] o_mf_pin,
    input wire logic [MF_N-1:0] o_mf_pin_oe,
    input wire logic [MF_N-1:0] o_mf_rise,
    input wire logic [MF_N-1:0] o_mf_fall
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_up; $past(i_rstn) && $rose(i_gp_pin[0]) && !i_gp_deb_en[0]; endsequence
    sequence s_dn; $past(i_rstn) && $fell(i_gp_pin[0]) && !i_gp_deb_en[0]; endsequence
    property p_gp_oe; $past(i_rstn) |-> o_gp_pin_oe == $past(i_gp_dir_out); endproperty
    a_gp_oe: assert property (p_gp_oe) else $error("gp enable wrong");
    property p_up; s_up |-> ##[2:4] o_gp_rise[0]; endproperty
    a_up: assert property (p_up) else $error("rise flag missing");
    property p_dn; s_dn |-> ##[2:4] o_gp_fall[0]; endproperty
    a_dn: assert property (p_dn) else $error("fall flag missing");
    property p_gp_hold;
        $past(i_rstn) |-> ($past(o_gp_rise & ~i_gp_rise_clr) & ~o_gp_rise) == '0;
    endproperty
    a_gp_hold: assert property (p_gp_hold) else $error("rise flag dropped");
    property p_mf_hold;
        $past(i_rstn) |-> ($past(o_mf_fall & ~i_mf_fall_clr) & ~o_mf_fall) == '0;
    endproperty
    a_mf_hold: assert property (p_mf_hold) else $error("mf flag dropped");
    property p_mf_off; !i_mf_port_en[0] |=> !o_mf_pin_oe[0]; endproperty
    a_mf_off: assert property (p_mf_off) else $error("mf drives unreleased");
    property p_mf_out;
        i_mf_port_en[1] && i_mf_mode[3:2] == 2'h1 |=>
            o_mf_pin_oe[1] && o_mf_pin[1] == $past(i_mf_out_val[1]);
    endproperty
    a_mf_out: assert property (p_mf_out) else $error("mf output wrong");
    property p_mf_quiet; !i_mf_port_en[0] [*4] |-> !$rose(o_mf_rise[0]); endproperty
    a_mf_quiet: assert property (p_mf_quiet) else $error("mf edge not refused");
endmodule : gep_port_assertions
bind gep_port gep_port_assertions #(.GP_N(GP_N), .MF_N(MF_N)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_gp_pin(i_gp_pin), .i_gp_deb_en(i_gp_deb_en),
    .i_gp_dir_out(i_gp_dir_out), .i_gp_rise_clr(i_gp_rise_clr),
    .i_mf_port_en(i_mf_port_en), .i_mf_mode(i_mf_mode), .i_mf_out_val(i_mf_out_val),
    .i_mf_fall_clr(i_mf_fall_clr), .o_gp_pin_oe(o_gp_pin_oe), .o_gp_rise(o_gp_rise),
    .o_gp_fall(o_gp_fall), .o_mf_pin(o_mf_pin), .o_mf_pin_oe(o_mf_pin_oe),
    .o_mf_rise(o_mf_rise), .o_mf_fall(o_mf_fall)
);

// ==== testbench/gep_switch.sv ====
// Purpose: Switches and peripherals on the port pins
// Assumes: Pins the port does not drive show the switch level
// Notes: No pull; the switch always drives a level
`timescale 1ns/1ps
module gep_switch #(parameter int N = 7) (
    // Port side
    input wire logic [N-1:0] i_oe,
    input wire logic [N-1:0] i_drv,
    // Switch side
    input wire logic [N-1:0] i_sw,
    output logic [N-1:0] o_pin
);
    assign o_pin = (i_oe & i_drv) | (~i_oe & i_sw);
endmodule : gep_switch

// ==== testbench/tb.sv ====
// Purpose: Self-checking bench for the pin port
// Assumes: Debounce shortened to 3 ticks; reference runs fast
// Notes: Flags are compared on every pin, listening or not
`timescale 1ns/1ps
module tb;
    logic i_clk = 0, i_rstn = 0, i_ref_32k = 0;
    logic [6:0] i_gp_pin, o_gp_pin, o_gp_pin_oe, o_gp_in, o_gp_rise, o_gp_fall;
    logic [6:0] i_gp_dir_out = 0, i_gp_out_val = 0, i_gp_deb_en = 0, gsw = 0;
    logic [6:0] i_gp_rise_clr = 0, i_gp_fall_clr = 0;
    logic [31:0] i_mf_pin, o_mf_pin, o_mf_pin_oe, o_mf_in, o_mf_rise, o_mf_fall, msw = 0;
    logic [31:0] i_mf_port_en = 0, i_mf_out_val = 0, i_mf_alt_val = 0;
    logic [31:0] i_mf_rise_clr = 0, i_mf_fall_clr = 0;
    logic [63:0] i_mf_mode = 0;
    int fails = 0, num_checks = 0, cyc = 0;
    gep_port #(.DEB_TICKS(3)) u_gep_port (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_ref_32k(i_ref_32k),
        .i_gp_pin(i_gp_pin), .o_gp_pin(o_gp_pin), .o_gp_pin_oe(o_gp_pin_oe),
        .i_gp_dir_out(i_gp_dir_out), .i_gp_out_val(i_gp_out_val), .i_gp_deb_en(i_gp_deb_en),
        .i_mf_pin(i_mf_pin), .o_mf_pin(o_mf_pin), .o_mf_pin_oe(o_mf_pin_oe),
        .i_mf_port_en(i_mf_port_en), .i_mf_mode(i_mf_mode), .i_mf_out_val(i_mf_out_val),
        .i_mf_alt_val(i_mf_alt_val), .o_gp_in(o_gp_in), .o_mf_in(o_mf_in),
        .o_gp_rise(o_gp_rise), .o_gp_fall(o_gp_fall), .o_mf_rise(o_mf_rise),
        .o_mf_fall(o_mf_fall), .i_gp_rise_clr(i_gp_rise_clr), .i_gp_fall_clr(i_gp_fall_clr),
        .i_mf_rise_clr(i_mf_rise_clr), .i_mf_fall_clr(i_mf_fall_clr)
    );
    gep_switch #(.N(7)) u_gep_switch (.i_oe(o_gp_pin_oe), .i_drv(o_gp_pin), .i_sw(gsw),
        .o_pin(i_gp_pin));
    gep_switch #(.N(32)) u_gep_switch_mf (.i_oe(o_mf_pin_oe), .i_drv(o_mf_pin), .i_sw(msw),
        .o_pin(i_mf_pin));
    initial forever #5 i_clk = ~i_clk;
    // Reference kept fast and off the clock grid, except every 50th toggle, which lands on a clock edge
    initial forever #53.3 i_ref_32k = ~i_ref_32k;
    task automatic cyc_n(input int n);
        repeat (n) @(posedge i_clk);
    endtask : cyc_n
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One compare per kind of result: pin drive, input level, edge flag
    task automatic chk_drv(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask : chk_drv
    task automatic chk_lvl(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask : chk_lvl
    task automatic chk_flg(input logic [31:0] got, input logic [31:0] exp);
        chk(got, exp);
    endtask : chk_flg
    task automatic finish_test;
        if (fails == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task automatic clr_all;
        {i_gp_rise_clr, i_gp_fall_clr, i_mf_rise_clr, i_mf_fall_clr} <= '1;
        cyc_n(1);
        {i_gp_rise_clr, i_gp_fall_clr, i_mf_rise_clr, i_mf_fall_clr} <= '0;
        cyc_n(2);
    endtask : clr_all
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] r, er, ef, dm, lm, dv;
        r = $urandom(32'h5d93fd4f);
        cyc_n(3);
        chk_drv({o_gp_pin_oe, o_gp_pin} | o_mf_pin_oe | o_mf_pin, '0);
        chk_flg({o_gp_rise, o_gp_fall} | o_mf_rise | o_mf_fall, '0);
        i_rstn <= 1;
        r = $urandom;
        i_gp_dir_out <= r[6:0];
        i_gp_out_val <= r[14:8];
        cyc_n(2);
        chk_drv(o_gp_pin_oe, i_gp_dir_out);
        chk_drv(o_gp_pin, i_gp_out_val);
        i_gp_dir_out <= '0;
        cyc_n(6);
        clr_all();
        er = '0;
        ef = '0;
        for (int k = 0; k < 2; k++) begin
            r = gsw ^ ($urandom | 32'h1);
            er = er | (r & ~gsw);
            ef = ef | (~r & gsw);
            gsw <= r[6:0];
            cyc_n(6);
            chk_lvl(o_gp_in, r[6:0]);
            chk_flg(o_gp_rise, er[6:0]);
            chk_flg(o_gp_fall, ef[6:0]);
        end
        clr_all();
        chk_flg(o_gp_rise | o_gp_fall, '0);
        for (int m = 0; m < 4; m++) begin
            i_mf_port_en <= ($urandom | 32'h2) & ~32'h1;
            i_mf_mode <= {32{m[1:0]}};
            i_mf_out_val <= $urandom;
            i_mf_alt_val <= $urandom;
            cyc_n(6);
            clr_all();
            r = $urandom;
            lm = i_mf_port_en & {32{m == 0 || m == 3}};
            dm = i_mf_port_en & {32{m == 1 || m == 2}};
            er = r & ~msw & lm;
            ef = ~r & msw & lm;
            msw <= r;
            // Test values move under driven pins but must raise no edge
            i_mf_alt_val <= $urandom;
            cyc_n(6);
            dv = (m == 1) ? i_mf_out_val : i_mf_alt_val;
            chk_drv(o_mf_pin_oe, dm);
            chk_drv(o_mf_pin & dm, dv & dm);
            chk_lvl(o_mf_in, (r & ~dm) | (dv & dm));
            chk_flg(o_mf_rise, er);
            chk_flg(o_mf_fall, ef);
        end
        gsw <= '0;
        i_gp_deb_en <= 7'h01;
        cyc_n(80);
        clr_all();
        // A pulse shorter than one reference period must be dropped
        gsw <= 7'h01;
        cyc_n(8);
        gsw <= '0;
        cyc_n(60);
        chk_lvl(o_gp_in, '0);
        chk_flg(o_gp_rise, '0);
        gsw <= 7'h01;
        cyc_n(15);
        chk_lvl(o_gp_in, '0);
        cyc_n(65);
        chk_lvl(o_gp_in, 32'h1);
        chk_flg(o_gp_rise, 32'h1);
        finish_test();
    end
endmodule : tb
